// file: ssrg_consts.svh
// timing constants for the supply supervisor reset gate
`ifndef SSRG_CONSTS_SVH
`define SSRG_CONSTS_SVH

`define SSRG_CLK_PERIOD_PS 5000
// reset timeout, nominal 200 ms (window 130 to 270 ms)
`define SSRG_TIMEOUT_MS 200
`define SSRG_TIMEOUT_MIN_MS 130
`define SSRG_TIMEOUT_MAX_MS 270
`define SSRG_TIMEOUT_CYC ((`SSRG_TIMEOUT_MS * 64'd1000000000) / `SSRG_CLK_PERIOD_PS)
// supply crossing to reset output, at most 5 us
`define SSRG_TRIP_DELAY_US 5
`define SSRG_TRIP_DELAY_CYC ((`SSRG_TRIP_DELAY_US * 1000000) / `SSRG_CLK_PERIOD_PS)
// supply glitch rejection, up to 30 ns ignored
`define SSRG_VGLITCH_NS 30
`define SSRG_VGLITCH_CYC (((`SSRG_VGLITCH_NS * 1000) + `SSRG_CLK_PERIOD_PS - 1) / `SSRG_CLK_PERIOD_PS)
// manual reset pulses under 100 ns rejected
`define SSRG_MGLITCH_NS 100
`define SSRG_MGLITCH_CYC (((`SSRG_MGLITCH_NS * 1000) + `SSRG_CLK_PERIOD_PS - 1) / `SSRG_CLK_PERIOD_PS)
// internal program cycle, at most 5 ms
`define SSRG_PROG_MS 5
`define SSRG_PROG_CYC ((`SSRG_PROG_MS * 64'd1000000000) / `SSRG_CLK_PERIOD_PS)

`endif

// file: ssrg_pkg.sv
// types for the supply supervisor reset gate
package ssrg_pkg;

    typedef enum logic [1:0] {
        SSRG_ST_LOW_SUPPLY,
        SSRG_ST_TIMEOUT,
        SSRG_ST_RUN
    } ssrg_state_e;

    // request from the serial memory front end
    typedef struct packed {
        logic bus_active;
        logic stop_after_write;
        logic addr_match;
    } ssrg_mem_req_s;

    // permissions returned to the serial memory front end
    typedef struct packed {
        logic bus_enable;
        logic abort_bus;
        logic ack_allowed;
        logic prog_busy;
        logic prog_start;
    } ssrg_mem_gate_s;

endpackage

// file: ssrg_filter.sv
// glitch filter: output follows input only once it held steady for MIN_CYC cycles
`timescale 1ns/10ps
module ssrg_filter #(
    parameter int MIN_CYC = 4,
    parameter bit INIT = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_raw,
    output logic o_level
);
    localparam int CW = $clog2(MIN_CYC + 1);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic level_reg;
    logic level_next;

    always_comb begin
        cnt_next = cnt_reg;
        level_next = level_reg;
        if (i_raw == level_reg) begin
            cnt_next = '0;
        end else if (cnt_reg >= CW'(MIN_CYC - 1)) begin
            level_next = i_raw;
            cnt_next = '0;
        end else begin
            cnt_next = cnt_reg + CW'(1);
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_reg <= '0;
            level_reg <= INIT;
        end else begin
            cnt_reg <= cnt_next;
            level_reg <= level_next;
        end
    end

    assign o_level = level_reg;
endmodule

// file: ssrg_top.sv
// supply supervisor: reset pulse generation and serial memory access gate
`timescale 1ns/10ps
`include "ssrg_consts.svh"
module ssrg_top
    import ssrg_pkg::*;
#(
    parameter bit ACTIVE_LOW = 1'b1,
    parameter longint TIMEOUT_CYC = `SSRG_TIMEOUT_CYC,
    parameter longint PROG_CYC = `SSRG_PROG_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_supply_ok,
    input wire logic i_rst_pin,
    input wire ssrg_pkg::ssrg_mem_req_s i_mem_req,
    output logic o_rst_pin_out,
    output logic o_rst_pin_oe,
    output logic o_reset_active,
    output ssrg_pkg::ssrg_mem_gate_s o_mem_gate
);
    import ssrg_pkg::*;

    localparam int TW = $clog2(TIMEOUT_CYC + 1);
    localparam int PW = $clog2(PROG_CYC + 1);
    localparam int VG_CYC = `SSRG_VGLITCH_CYC + 1;
    localparam int MG_CYC = `SSRG_MGLITCH_CYC + 1;
    // cycles after releasing the pin before the synchronised pin shows the far side
    localparam int PEEK_CYC = 2;

    //////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic supply_s1_reg;
    logic supply_s2_reg;
    logic pin_s1_reg;
    logic pin_s2_reg;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            supply_s1_reg <= 1'b0;
            supply_s2_reg <= 1'b0;
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
        end else begin
            supply_s1_reg <= i_supply_ok;
            supply_s2_reg <= supply_s1_reg;
            pin_s1_reg <= i_rst_pin;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // glitch filters
    logic supply_ok_f;
    logic pin_level_f;
    logic pin_low_raw;

    // low supply only counts once it outlasts the glitch width; the filter adds
    // a few tens of ns, far inside the 5 us trip budget
    ssrg_filter #(.MIN_CYC(VG_CYC), .INIT(1'b0)) u_supply_filt (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_raw(supply_s2_reg),
        .o_level(supply_ok_f)
    );

    // pin read as "asserted" level; active-high variant has no manual input
    assign pin_low_raw = ACTIVE_LOW ? ~pin_s2_reg : 1'b0;

    ssrg_filter #(.MIN_CYC(MG_CYC), .INIT(1'b0)) u_pin_filt (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_raw(pin_low_raw),
        .o_level(pin_level_f)
    );

    //////////////////////////////////////////////////////////////////////////
    // reset state machine
    ssrg_state_e state_reg;
    ssrg_state_e state_next;
    logic [TW-1:0] tmr_reg;
    logic [TW-1:0] tmr_next;
    logic pin_prev_reg;
    logic pin_prev_next;
    logic manual_edge;
    logic rst_act_reg;
    logic rst_act_next;
    logic pin_oe_reg;

    // edge detect on the filtered asserted level (high-to-low on the pin); while we
    // drive the pin low we only read back our own drive, so edges count when released
    assign manual_edge = pin_level_f & ~pin_prev_reg & ~pin_oe_reg;

    always_comb begin
        state_next = state_reg;
        tmr_next = tmr_reg;
        pin_prev_next = pin_level_f;
        case (state_reg)
            SSRG_ST_LOW_SUPPLY: begin
                tmr_next = '0;
                if (supply_ok_f) begin
                    state_next = SSRG_ST_TIMEOUT;
                end
            end
            SSRG_ST_TIMEOUT: begin
                if (!supply_ok_f) begin
                    state_next = SSRG_ST_LOW_SUPPLY;
                end else if (manual_edge) begin
                    tmr_next = '0;
                end else if (tmr_reg >= TW'(TIMEOUT_CYC - 1)) begin
                    state_next = SSRG_ST_RUN;
                    tmr_next = '0;
                end else begin
                    tmr_next = tmr_reg + TW'(1);
                end
            end
            SSRG_ST_RUN: begin
                if (!supply_ok_f) begin
                    state_next = SSRG_ST_LOW_SUPPLY;
                    tmr_next = '0;
                end else if (manual_edge) begin
                    state_next = SSRG_ST_TIMEOUT;
                    tmr_next = '0;
                end else if (tmr_reg == TW'(PEEK_CYC)) begin
                    // pin still low after our release: someone holds it, so reset is kept
                    // and the full timeout runs again from here
                    if (pin_low_raw) begin
                        state_next = SSRG_ST_TIMEOUT;
                        tmr_next = '0;
                    end else begin
                        tmr_next = TW'(PEEK_CYC + 1);
                    end
                end else if (tmr_reg < TW'(PEEK_CYC)) begin
                    tmr_next = tmr_reg + TW'(1);
                end
            end
            default: begin
                state_next = SSRG_ST_LOW_SUPPLY;
                tmr_next = '0;
            end
        endcase
        // the reset condition outlasts the pin drive by the look-back window
        rst_act_next = (state_next != SSRG_ST_RUN) || (tmr_next <= TW'(PEEK_CYC));
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= SSRG_ST_LOW_SUPPLY;
            tmr_reg <= '0;
            pin_prev_reg <= 1'b0;
            rst_act_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            pin_prev_reg <= pin_prev_next;
            rst_act_reg <= rst_act_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pin driver: open drain on the active-low variant, drive released after
    // timeout; active-high variant drives high only during reset
    logic pin_out_reg;
    logic pin_out_next;
    logic pin_oe_next;

    always_comb begin
        pin_out_next = ACTIVE_LOW ? 1'b0 : 1'b1;
        pin_oe_next = (state_next != SSRG_ST_RUN);
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_out_reg <= ACTIVE_LOW ? 1'b0 : 1'b1;
            pin_oe_reg <= 1'b1;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // memory access gate and program cycle timer
    logic [PW-1:0] prog_reg;
    logic [PW-1:0] prog_next;
    logic busy_reg;
    logic busy_next;
    logic start_reg;
    logic start_next;
    ssrg_mem_gate_s gate_reg;
    ssrg_mem_gate_s gate_next;

    always_comb begin
        busy_next = busy_reg;
        prog_next = prog_reg;
        start_next = 1'b0;
        if (busy_reg) begin
            // a running cycle is never cut short, reset or not
            if (prog_reg >= PW'(PROG_CYC - 1)) begin
                busy_next = 1'b0;
                prog_next = '0;
            end else begin
                prog_next = prog_reg + PW'(1);
            end
        end else if (i_mem_req.stop_after_write && !rst_act_reg) begin
            busy_next = 1'b1;
            start_next = 1'b1;
            prog_next = '0;
        end
        gate_next.prog_busy = busy_next;
        gate_next.prog_start = start_next;
        gate_next.bus_enable = !rst_act_next && !busy_next;
        gate_next.abort_bus = rst_act_next && i_mem_req.bus_active;
        gate_next.ack_allowed = gate_next.bus_enable && i_mem_req.addr_match;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            prog_reg <= '0;
            busy_reg <= 1'b0;
            start_reg <= 1'b0;
            gate_reg <= '0;
        end else begin
            prog_reg <= prog_next;
            busy_reg <= busy_next;
            start_reg <= start_next;
            gate_reg <= gate_next;
        end
    end

    assign o_rst_pin_out = pin_out_reg;
    assign o_rst_pin_oe = pin_oe_reg;
    assign o_reset_active = rst_act_reg;
    assign o_mem_gate = gate_reg;
endmodule

// file: ssrg_top_monitor.sv
// assertion checker for the supervisor reset gate
`timescale 1ns/10ps
module ssrg_top_monitor
    import ssrg_pkg::*;
#(
    parameter bit ACTIVE_LOW = 1'b1,
    parameter longint TIMEOUT_CYC = 50,
    parameter longint PROG_CYC = 20
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_supply_ok,
    input wire logic o_rst_pin_out,
    input wire logic o_rst_pin_oe,
    input wire logic o_reset_active,
    input wire ssrg_pkg::ssrg_mem_gate_s o_mem_gate
);
    logic [31:0] busy_cnt_reg;
    logic [31:0] rst_cnt_reg;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // run lengths, because the counts exceed what a repetition may hold
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            busy_cnt_reg <= 32'h0;
            rst_cnt_reg <= 32'h0;
        end else begin
            busy_cnt_reg <= o_mem_gate.prog_busy ? busy_cnt_reg + 32'h1 : 32'h0;
            rst_cnt_reg <= o_reset_active ? rst_cnt_reg + 32'h1 : 32'h0;
        end
    end
    sequence s_supply_low;
        !i_supply_ok [*8];
    endsequence
    sequence s_prog_begin;
        o_mem_gate.prog_start ##1 !o_mem_gate.prog_start;
    endsequence
    AST_SUPPLY_TRIP: assert property (s_supply_low |-> ##[0:12] o_reset_active)
        else $error("reset late after supply loss");
    AST_HOLD_TIME: assert property ($fell(o_reset_active) |-> rst_cnt_reg >= TIMEOUT_CYC)
        else $error("reset shorter than timeout");
    AST_PIN_RELEASE: assert property ($fell(o_reset_active) |-> ##[0:1] !o_rst_pin_oe)
        else $error("pin still driven after timeout");
    AST_PIN_LEVEL: assert property (o_rst_pin_oe |-> o_rst_pin_out == !ACTIVE_LOW)
        else $error("pin driven to wrong level");
    AST_RESET_GATE: assert property (o_reset_active |-> !o_mem_gate.bus_enable)
        else $error("bus enabled in reset");
    AST_ABORT: assert property (o_mem_gate.abort_bus |-> o_reset_active)
        else $error("abort outside reset");
    AST_NO_START_IN_RESET: assert property (o_mem_gate.prog_start |-> !$past(o_reset_active))
        else $error("program started in reset");
    AST_PROG_LEN: assert property ($fell(o_mem_gate.prog_busy) |-> busy_cnt_reg == PROG_CYC)
        else $error("program cycle length wrong");
    AST_PROG_BEGIN: assert property (s_prog_begin |-> o_mem_gate.prog_busy && !o_mem_gate.bus_enable)
        else $error("bus not closed at program start");
    AST_BUSY_NO_ACK: assert property (o_mem_gate.prog_busy && $past(o_mem_gate.prog_busy)
        |-> !o_mem_gate.ack_allowed)
        else $error("address ack while programming");
endmodule

bind ssrg_top ssrg_top_monitor #(.ACTIVE_LOW(ACTIVE_LOW), .TIMEOUT_CYC(TIMEOUT_CYC), .PROG_CYC(PROG_CYC))
    ssrg_top_monitor_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_supply_ok(i_supply_ok),
    .o_rst_pin_out(o_rst_pin_out), .o_rst_pin_oe(o_rst_pin_oe), .o_reset_active(o_reset_active),
    .o_mem_gate(o_mem_gate));

// file: ssrg_host_model.sv
// host side of the reset line: push button and pull-up resistor
`timescale 1ns/10ps
module ssrg_host_model (
    input wire logic i_press,
    input wire logic i_drv_out,
    input wire logic i_drv_oe,
    output logic o_pin
);
    // open-drain wire: any party pulling low wins, otherwise the pull-up holds it high
    assign o_pin = !(i_press || (i_drv_oe && !i_drv_out));
endmodule

// file: ssrg_top_test.sv
// self-checking bench for the supervisor reset gate
`timescale 1ns/10ps
module ssrg_top_test;
    import ssrg_pkg::*;
    localparam longint TO = 50;
    localparam longint PC = 20;
    typedef struct {logic sup; int wid; logic exp;} ssrg_row_s;
    ssrg_row_s rows[5] = '{'{1'h1, 4, 1'h0}, '{1'h1, 12, 1'h1}, '{1'h0, 10, 1'h0}, '{1'h0, 30, 1'h1},
        '{1'h0, 80, 1'h1}};
    logic i_clk, i_sys_rst, i_supply_ok, press, pin, rst_out, rst_oe, rst_act;
    ssrg_mem_req_s req;
    ssrg_mem_gate_s gate;
    int mismatches, samples_checked, n, k;
    ssrg_top #(.TIMEOUT_CYC(TO), .PROG_CYC(PC)) ssrg_top_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_supply_ok(i_supply_ok), .i_rst_pin(pin), .i_mem_req(req), .o_rst_pin_out(rst_out),
        .o_rst_pin_oe(rst_oe), .o_reset_active(rst_act), .o_mem_gate(gate));
    ssrg_host_model ssrg_host_model_inst (.i_press(press), .i_drv_out(rst_out), .i_drv_oe(rst_oe), .o_pin(pin));
    initial begin
        i_clk = 1'h0;
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    // bounded wait for the reset condition to reach a level
    task automatic wait_rst(input logic v, output int cyc);
        cyc = 0;
        while (rst_act !== v) begin
            @(posedge i_clk);
            cyc++;
            if (cyc > 400) begin
                mismatches++;
                print_verdict();
            end
        end
    endtask
    task automatic pulse(input logic sup, input int wid);
        @(posedge i_clk);
        if (sup) i_supply_ok <= 1'h0;
        else press <= 1'h1;
        repeat (wid) @(posedge i_clk);
        i_supply_ok <= 1'h1;
        press <= 1'h0;
    endtask
    task automatic stop_pulse;
        @(posedge i_clk);
        req.stop_after_write <= 1'h1;
        @(posedge i_clk);
        req.stop_after_write <= 1'h0;
    endtask
    // counts busy cycles; zero when no program cycle starts
    task automatic prog_len(output int cyc);
        cyc = 0;
        repeat (3) begin
            @(posedge i_clk);
            if (gate.prog_busy === 1'h1) break;
        end
        while (gate.prog_busy === 1'h1 && cyc < 100) begin
            @(posedge i_clk);
            cyc++;
        end
    endtask
    initial begin
        i_sys_rst = 1'h1;
        i_supply_ok = 1'h1;
        press = 1'h0;
        req = '0;
        mismatches = 0;
        samples_checked = 0;
        repeat (8) @(posedge i_clk);
        check(rst_act & rst_oe, 1'h1);
        check(gate, 5'h0);
        i_sys_rst <= 1'h0;
        wait_rst(1'h0, n);
        check(n >= TO && n <= TO + 30, 1'h1);
        @(posedge i_clk);
        check({rst_oe, pin}, 2'h1);
        foreach (rows[i]) begin
            pulse(rows[i].sup, rows[i].wid);
            k = 0;
            while (rst_act !== 1'h1 && k < 30) begin
                @(posedge i_clk);
                k++;
            end
            check(rst_act, rows[i].exp);
            if (rows[i].exp) begin
                check(pin, 1'h0);
                wait_rst(1'h0, n);
                check(k + n + rows[i].wid >= TO + 20 && k + n <= TO + 40, 1'h1);
                // the echo of the block's own drive must leave the pin filter before the next press
                repeat (30) @(posedge i_clk);
            end
        end
        // memory traffic first once reset has gone, as the host must, then again after the supply drops and reset is active
        req.addr_match <= 1'h1;
        stop_pulse();
        prog_len(n);
        check(n, PC);
        repeat (3) @(posedge i_clk);
        check({gate.bus_enable, gate.ack_allowed}, 2'h3);
        stop_pulse();
        i_supply_ok <= 1'h0;
        prog_len(n);
        check({rst_act, n[7:0]}, {1'h1, 8'(PC)});
        req.bus_active <= 1'h1;
        stop_pulse();
        prog_len(n);
        check(n, 0);
        check({gate.abort_bus, gate.bus_enable}, 2'h2);
        i_supply_ok <= 1'h1;
        req.bus_active <= 1'h0;
        wait_rst(1'h0, n);
        check(n >= TO, 1'h1);
        print_verdict();
    end
endmodule
